/* hdl/spim_axil.sv */
// AXI4-Lite slave front end with simple register strobes
`timescale 1ns/100ps
module spim_axil (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  input wire logic wr_ok,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  logic aw_have_ff;
  logic w_have_ff;
  logic [7:0] awaddr_ff;
  logic [7:0] wdata_ff;
  logic wlane_ff;
  logic do_wr;

  assign s_axi_awready = !aw_have_ff;
  assign s_axi_wready = !w_have_ff;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_wr = aw_have_ff && w_have_ff && !s_axi_bvalid;
  assign wr_en = do_wr && wlane_ff;
  assign wr_addr = awaddr_ff;
  assign wr_data = wdata_ff;
  assign rd_addr = s_axi_araddr;

  // Capture address and data in either order
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      wlane_ff <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_have_ff) begin
        aw_have_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_have_ff <= 1'b0;
      end
      if (s_axi_wvalid && !w_have_ff) begin
        w_have_ff <= 1'b1;
        wdata_ff <= s_axi_wdata[7:0];
        wlane_ff <= s_axi_wstrb[0];
      end else if (do_wr) begin
        w_have_ff <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= spim_pkg::SPIM_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? spim_pkg::SPIM_OKAY : spim_pkg::SPIM_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read answer one cycle after address is taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= spim_pkg::SPIM_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_ok ? spim_pkg::SPIM_OKAY : spim_pkg::SPIM_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : spim_axil

/* hdl/spim_defines.svh */
// Offsets, fields, reset values and timing of the serial master block
// How it works
// - Pins serve master only while enable set
// - Master drives clock, data out, select
// - Polarity picks inverted or normal clock
// - Phase picks first or second sampling edge
// - Length field gives 1 to 24 bits
// - Transmit low byte least, high most
// - Execute 0x01 lowers select, starts shifting
// - Execute 0x02 raises select, no start
// - Captured bits land in receive bytes
// - Loopback feeds transmit into receive path
// - Loopback uses same registers, pins frozen
// - Loopback leaves sent bytes in receive
// - Select pin holds value at loopback entry
`ifndef SPIM_DEFINES_SVH
`define SPIM_DEFINES_SVH
// ****************************************
// Register byte addresses
// ****************************************
`define SPIM_A_PINCFG 8'h00
`define SPIM_A_CFG 8'h04
`define SPIM_A_TXLO 8'h08
`define SPIM_A_TXMID 8'h0c
`define SPIM_A_TXHI 8'h10
`define SPIM_A_EXE 8'h14
`define SPIM_A_RXLO 8'h18
`define SPIM_A_RXMID 8'h1c
`define SPIM_A_RXHI 8'h20
`define SPIM_A_DIAG 8'h24
`define SPIM_A_STAT 8'h28
// ****************************************
// Field positions and values
// ****************************************
`define SPIM_F_PIN_EN 0
`define SPIM_F_CPOL 5
`define SPIM_F_CPHA 6
`define SPIM_F_GO 0
`define SPIM_F_SS 1
`define SPIM_F_LOOP 0
`define SPIM_F_BUSY 0
`define SPIM_F_DONE 1
`define SPIM_MAX_BITS 5'h18
`define SPIM_RST_SS 1'b1
`define SPIM_RST_CFG 7'h08
// ****************************************
// Timing
// ****************************************
`define SPIM_CLK_NS 4
`define SPIM_HALF_NS 24
`define SPIM_HALF_CYC (`SPIM_HALF_NS / `SPIM_CLK_NS)
`endif

/* hdl/spim_pkg.sv */
// Types shared by the serial master block
package spim_pkg;
  typedef enum logic {SPIM_IDLE, SPIM_RUN} spim_state_t;
  typedef logic [1:0] spim_resp_t;
  localparam spim_resp_t SPIM_OKAY = 2'h0;
  localparam spim_resp_t SPIM_SLVERR = 2'h2;
endpackage : spim_pkg

/* hdl/spim_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module spim_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // ****************************************
  // One two-flop chain per bit
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_ff;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_ff <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          meta_ff <= d[i];
          q[i] <= meta_ff;
        end
      end
    end
  endgenerate
endmodule : spim_sync

/* hdl/spim_top.sv */
// Serial master with loopback, pin muxing and register file
`timescale 1ns/100ps
`include "spim_defines.svh"
module spim_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic sclk_o,
  output logic sclk_oe,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic ss_o,
  output logic ss_oe
);
  localparam logic [3:0] HALF_CYC = 4'(`SPIM_HALF_CYC);

  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_ok;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  logic miso_sync;

  logic pin_en_ff;
  logic [6:0] cfg_ff;
  logic [23:0] tx_ff;
  logic [23:0] rx_ff;
  logic ss_ctrl_ff;
  logic loop_ff;
  logic done_ff;
  spim_pkg::spim_state_t state_ff;
  logic [3:0] div_ff;
  logic [5:0] edge_ff;
  logic [5:0] last_edge_ff;
  logic sclk_ff;
  logic mosi_ff;
  logic [23:0] txsh_ff;
  logic [23:0] rxsh_ff;
  logic [4:0] nbits;
  logic cpol;
  logic cpha;
  logic go;
  logic tick;
  logic leading;
  logic drive_edge;
  logic sample_edge;
  logic rx_bit;
  logic [23:0] tx_aligned;

  // ****************************************
  // Bus front end and pin input sync
  // ****************************************
  spim_axil u_axil (
    .clk(clk),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  spim_sync #(.W(1)) u_miso_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(miso_i),
    .q(miso_sync)
  );

  // ****************************************
  // Register decode
  // ****************************************
  // Clamp length into 1..24
  assign nbits = (cfg_ff[4:0] == 5'h00) ? 5'h01 :
                 (cfg_ff[4:0] > `SPIM_MAX_BITS) ? `SPIM_MAX_BITS : cfg_ff[4:0];
  assign cpol = cfg_ff[`SPIM_F_CPOL];
  assign cpha = cfg_ff[`SPIM_F_CPHA];
  assign go = wr_en && (wr_addr == `SPIM_A_EXE) && wr_data[`SPIM_F_GO]
              && (state_ff == spim_pkg::SPIM_IDLE);

  // Known write targets
  always_comb begin
    unique case (wr_addr)
      `SPIM_A_PINCFG, `SPIM_A_CFG, `SPIM_A_TXLO, `SPIM_A_TXMID,
      `SPIM_A_TXHI, `SPIM_A_EXE, `SPIM_A_DIAG: wr_ok = 1'b1;
      `SPIM_A_RXLO, `SPIM_A_RXMID, `SPIM_A_RXHI, `SPIM_A_STAT: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Read mux, upper bits zero
  always_comb begin
    rd_ok = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      `SPIM_A_PINCFG: rd_data[0] = pin_en_ff;
      `SPIM_A_CFG: rd_data[6:0] = cfg_ff;
      `SPIM_A_TXLO: rd_data[7:0] = tx_ff[7:0];
      `SPIM_A_TXMID: rd_data[7:0] = tx_ff[15:8];
      `SPIM_A_TXHI: rd_data[7:0] = tx_ff[23:16];
      `SPIM_A_EXE: rd_data[`SPIM_F_SS] = ss_ctrl_ff;
      `SPIM_A_RXLO: rd_data[7:0] = rx_ff[7:0];
      `SPIM_A_RXMID: rd_data[7:0] = rx_ff[15:8];
      `SPIM_A_RXHI: rd_data[7:0] = rx_ff[23:16];
      `SPIM_A_DIAG: rd_data[`SPIM_F_LOOP] = loop_ff;
      `SPIM_A_STAT: begin
        rd_data[`SPIM_F_BUSY] = (state_ff == spim_pkg::SPIM_RUN);
        rd_data[`SPIM_F_DONE] = done_ff;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // ****************************************
  // Software registers
  // ****************************************
  // Configuration and transmit bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_en_ff <= 1'b0;
      cfg_ff <= `SPIM_RST_CFG;
      tx_ff <= 24'h00_0000;
      loop_ff <= 1'b0;
    end else if (wr_en) begin
      unique case (wr_addr)
        `SPIM_A_PINCFG: pin_en_ff <= wr_data[`SPIM_F_PIN_EN];
        `SPIM_A_CFG: cfg_ff <= wr_data[6:0];
        `SPIM_A_TXLO: tx_ff[7:0] <= wr_data;
        `SPIM_A_TXMID: tx_ff[15:8] <= wr_data;
        `SPIM_A_TXHI: tx_ff[23:16] <= wr_data;
        `SPIM_A_DIAG: loop_ff <= wr_data[`SPIM_F_LOOP];
        default: ;
      endcase
    end
  end

  // Select control from execute writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ss_ctrl_ff <= `SPIM_RST_SS;
    end else if (wr_en && wr_addr == `SPIM_A_EXE) begin
      ss_ctrl_ff <= wr_data[`SPIM_F_SS];
    end
  end

  // ****************************************
  // Shift engine
  // ****************************************
  assign tick = (div_ff == 4'h0);
  assign leading = !edge_ff[0];
  assign drive_edge = cpha ? leading : (!leading && edge_ff != last_edge_ff);
  assign sample_edge = leading ^ cpha;
  assign rx_bit = loop_ff ? mosi_ff : miso_sync;
  assign tx_aligned = tx_ff << (6'h18 - {1'b0, nbits});

  // Half period divider
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 4'h0;
    end else if (state_ff == spim_pkg::SPIM_IDLE || tick) begin
      div_ff <= HALF_CYC - 4'h1;
    end else begin
      div_ff <= div_ff - 4'h1;
    end
  end

  // Sequencer and edge counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= spim_pkg::SPIM_IDLE;
      edge_ff <= 6'h00;
      last_edge_ff <= 6'h00;
      done_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        spim_pkg::SPIM_IDLE: begin
          if (go) begin
            state_ff <= spim_pkg::SPIM_RUN;
            edge_ff <= 6'h00;
            last_edge_ff <= {nbits, 1'b0} - 6'h01;
            done_ff <= 1'b0;
          end
        end
        spim_pkg::SPIM_RUN: begin
          if (tick) begin
            edge_ff <= edge_ff + 6'h01;
            if (edge_ff == last_edge_ff) begin
              state_ff <= spim_pkg::SPIM_IDLE;
              done_ff <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Internal clock, idles at polarity
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_ff <= 1'b0;
    end else if (state_ff == spim_pkg::SPIM_IDLE) begin
      sclk_ff <= cpol;
    end else if (tick) begin
      sclk_ff <= !sclk_ff;
    end
  end

  // Data out shifting, MSB first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mosi_ff <= 1'b0;
      txsh_ff <= 24'h00_0000;
    end else if (go) begin
      mosi_ff <= cpha ? mosi_ff : tx_aligned[23];
      txsh_ff <= cpha ? tx_aligned : (tx_aligned << 1);
    end else if (state_ff == spim_pkg::SPIM_RUN && tick && drive_edge) begin
      mosi_ff <= txsh_ff[23];
      txsh_ff <= txsh_ff << 1;
    end
  end

  // Data in capture and receive bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxsh_ff <= 24'h00_0000;
      rx_ff <= 24'h00_0000;
    end else if (go) begin
      rxsh_ff <= 24'h00_0000;
    end else if (state_ff == spim_pkg::SPIM_RUN && tick) begin
      if (sample_edge) begin
        rxsh_ff <= {rxsh_ff[22:0], rx_bit};
      end
      // Phase 0 ends on a trailing edge, shifter already full
      if (edge_ff == last_edge_ff) begin
        rx_ff <= sample_edge ? {rxsh_ff[22:0], rx_bit} : rxsh_ff;
      end
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  // Pins frozen while loopback runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_o <= 1'b0;
      mosi_o <= 1'b0;
      ss_o <= `SPIM_RST_SS;
    end else if (!loop_ff) begin
      sclk_o <= sclk_ff;
      mosi_o <= mosi_ff;
      ss_o <= ss_ctrl_ff;
    end
  end

  // Enables follow pin function setting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_oe <= 1'b0;
      mosi_oe <= 1'b0;
      ss_oe <= 1'b0;
    end else begin
      sclk_oe <= pin_en_ff;
      mosi_oe <= pin_en_ff;
      ss_oe <= pin_en_ff;
    end
  end
endmodule : spim_top

/* sim/spi_master_with_loopback_test.sv */
// Self-checking bench for the serial master with loopback
`timescale 1ns/100ps
`include "spim_defines.svh"
module spi_master_with_loopback_test;
  logic clk = 1'b0, rst_n = 1'b0, cpol = 1'b0, cpha = 1'b0, miso;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sclk_o, sclk_oe, mosi_o, mosi_oe, ss_o, ss_oe;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic [23:0] reply = 24'h0, got;
  logic [15:0] seed = 16'ha538;
  logic [3:0] wstrb = 4'hf;
  logic [31:0] exp_q[$];
  int errors = 0, samples_checked = 0, cyc = 0;
  int lens[8] = '{1, 24, 8, 17, 5, 23, 12, 24};
  // Clock
  always #2 clk = ~clk;
  spim_top dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sclk_o(sclk_o), .sclk_oe(sclk_oe), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso),
    .ss_o(ss_o), .ss_oe(ss_oe));
  spim_slave_model u_slave (.sclk(sclk_o), .mosi(mosi_o), .ss_n(ss_o), .cpol(cpol),
    .cpha(cpha), .reply(reply), .miso(miso), .got(got));
  // ****************************************
  // Checks and bus tasks
  // ****************************************
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("FAIL %0t value %h expected %h", $time, g, e);
    end
  endtask : chk_val
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("FAIL %0t response %h expected %h", $time, g, e);
    end
  endtask : chk_resp
  function automatic logic [23:0] rnd();
    logic [23:0] v;
    v = 24'h00_0000;
    for (int k = 0; k < 24; k++) begin
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      v = {v[22:0], seed[0]};
    end
    return v;
  endfunction : rnd
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (awready === 1'b1 && !aw_ok) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !w_ok) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    @(posedge clk);
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    @(posedge clk);
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  // One transfer, normal or loopback, in a given clock format
  task automatic xfer(input int i);
    logic [31:0] d, rx, mask;
    logic [23:0] tx, rp;
    logic [1:0] r;
    logic [2:0] pins;
    logic lp;
    lp = (i >= 6);
    tx = rnd();
    rp = rnd();
    cpol <= i[0];
    cpha <= i[1];
    reply <= rp;
    mask = (32'h1 << lens[i]) - 32'h1;
    wr(`SPIM_A_CFG, {25'h0, i[1], i[0], lens[i][4:0]}, r);
    wr(`SPIM_A_TXLO, {24'h0, tx[7:0]}, r);
    wr(`SPIM_A_TXMID, {24'h0, tx[15:8]}, r);
    wr(`SPIM_A_TXHI, {24'h0, tx[23:16]}, r);
    chk_val({31'h0, sclk_o}, {31'h0, i[0]});
    if (lp) begin
      wr(`SPIM_A_DIAG, 32'h1, r);
      pins = {sclk_o, mosi_o, ss_o};
    end
    exp_q.push_back(lp ? ({8'h0, tx} & mask) : ({8'h0, rp} >> (24 - lens[i])));
    wr(`SPIM_A_EXE, 32'h1, r);
    rd(`SPIM_A_STAT, d, r);
    chk_val(d & 32'h1, 32'h1);
    chk_val({31'h0, ss_o}, {31'h0, lp});
    do rd(`SPIM_A_STAT, d, r); while (d[0] !== 1'b0);
    chk_val(d & 32'h3, 32'h2);
    rd(`SPIM_A_RXLO, d, r);
    rx = d & 32'hff;
    rd(`SPIM_A_RXMID, d, r);
    rx = rx | ((d & 32'hff) << 8);
    rd(`SPIM_A_RXHI, d, r);
    rx = rx | ((d & 32'hff) << 16);
    chk_val(rx, exp_q.pop_front());
    if (lp) chk_val({29'h0, sclk_o, mosi_o, ss_o}, {29'h0, pins});
    else chk_val({8'h0, got} & mask, {8'h0, tx} & mask);
    wr(`SPIM_A_EXE, 32'h2, r);
    repeat (3) @(posedge clk);
    chk_val({31'h0, ss_o}, 32'h1);
    if (lp) wr(`SPIM_A_DIAG, 32'h0, r);
  endtask : xfer
  // Cycle limit
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      stop_test();
    end
  end
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk_val({29'h0, sclk_oe, mosi_oe, ss_oe}, 32'h0);
    rd(`SPIM_A_CFG, d, r);
    chk_val(d, {25'h0, `SPIM_RST_CFG});
    // Write with the low lane off stores nothing
    wstrb <= 4'h0;
    wr(`SPIM_A_CFG, 32'h0000_007f, r);
    chk_resp(r, spim_pkg::SPIM_OKAY);
    wstrb <= 4'hf;
    rd(`SPIM_A_CFG, d, r);
    chk_val(d, {25'h0, `SPIM_RST_CFG});
    rd(8'h2c, d, r);
    chk_resp(r, spim_pkg::SPIM_SLVERR);
    chk_val(d, 32'h0000_0000);
    wr(8'h30, 32'h1, r);
    chk_resp(r, spim_pkg::SPIM_SLVERR);
    wr(`SPIM_A_PINCFG, 32'h1, r);
    chk_resp(r, spim_pkg::SPIM_OKAY);
    repeat (2) @(posedge clk);
    chk_val({29'h0, sclk_oe, mosi_oe, ss_oe}, 32'h7);
    for (int i = 0; i < 8; i++) xfer(i);
    wr(`SPIM_A_PINCFG, 32'h0, r);
    repeat (2) @(posedge clk);
    chk_val({29'h0, sclk_oe, mosi_oe, ss_oe}, 32'h0);
    stop_test();
  end
endmodule : spi_master_with_loopback_test

/* sim/spim_slave_model.sv */
// Behavioural serial slave on the far side of the pins
`timescale 1ns/100ps
module spim_slave_model (
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ss_n,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [23:0] reply,
  output logic miso,
  output logic [23:0] got
);
  int idx;
  initial miso = 1'b0;
  // Load reply, first bit out at select for phase 0
  always @(negedge ss_n) begin
    got = 24'h000000;
    idx = 23;
    if (!cpha) begin
      miso = reply[idx];
      idx--;
    end
  end
  // Released line shows the inverse of the last bit
  always @(posedge ss_n) miso = ~miso;
  // Sample on the phase-chosen edge, shift on the other
  always @(sclk) begin
    if (!ss_n) begin
      if ((sclk != cpol) ^ cpha) begin
        got = {got[22:0], mosi};
      end else if (idx >= 0) begin
        miso = reply[idx];
        idx--;
      end
    end
  end
endmodule : spim_slave_model

/* sim/spim_top_asserts.sv */
// Port-level checks for the serial master
`timescale 1ns/100ps
module spim_top_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sclk_o,
  input wire logic sclk_oe,
  input wire logic mosi_oe,
  input wire logic ss_o,
  input wire logic ss_oe
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Pin drivers switch together
  AST_OE_SAME: assert property (sclk_oe == mosi_oe && mosi_oe == ss_oe)
    else $error("pin enables differ");
  // Serial clock holds a full half period
  AST_SCLK_HALF: assert property ($changed(sclk_o) |=> $stable(sclk_o) [*5])
    else $error("serial clock half period short");
  // Select moves only after a register write
  AST_SS_CAUSE: assert property ($changed(ss_o) |->
    s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("select moved without a write");
  // Pin enables move only after a register write
  AST_OE_CAUSE: assert property ($changed(sclk_oe) |-> $past(s_axi_bvalid))
    else $error("pin enable moved without a write");
  // Write answer follows the accepted pair
  AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer missing");
  // Write answer stands until taken
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  // Read answer one cycle after address
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // Read answer and data stand until taken
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed");
  // No new read address while answering
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  // Main scenarios seen
  COV_SEL: cover property ($fell(ss_o));
  COV_SCLK: cover property ($changed(sclk_o));
  COV_RSTALL: cover property (s_axi_rvalid && !s_axi_rready);
endmodule : spim_top_asserts
bind spim_top spim_top_asserts u_asserts (
  .clk(clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .sclk_o(sclk_o), .sclk_oe(sclk_oe), .mosi_oe(mosi_oe), .ss_o(ss_o), .ss_oe(ss_oe)
);
